// file: bench/pwm_shared_period_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_shared_period_monitor
    import pwm_shared_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [NUM_CH-1:0] pwm_out,
    input wire logic [NUM_CH-1:0] pwm_oe,
    input wire logic              irq
);
    // ----------------------------------------
    // shadow copies of the enable bits
    // ----------------------------------------
    localparam logic [11:0] A_CFG = {IDX_CFG, 2'b00};
    localparam logic [11:0] A_IE  = {IDX_IRQ_EN, 2'b00};
    localparam logic [11:0] A_MSK = {IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_CNT = {IDX_COUNT, 2'b00};
    logic wr;
    logic en_ff;
    logic ie_ff;
    logic msk_ff;
    assign wr = psel && penable && pready && pwrite;
    // follow committed writes only, so refused cycles never move the shadow
    always_ff @(posedge clk) begin
        if (rst) begin
            en_ff  <= 1'b0;
            ie_ff  <= 1'b0;
            msk_ff <= 1'b0;
        end else begin
            en_ff  <= (wr && paddr == A_CFG) ? pwdata[CFG_EN_BIT] : en_ff;
            ie_ff  <= (wr && paddr == A_IE) ? pwdata[IRQ_EN_BIT] : ie_ff;
            msk_ff <= (wr && paddr == A_MSK) ? |pwdata[7:0] : msk_ff;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_access;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_off;
        !en_ff [*3];
    endsequence
    // the counter clears two cycles after the enable drops, so a back-to-back read needs one more
    sequence s_off_long;
        !en_ff [*4];
    endsequence
    sequence s_quiet;
        (!ie_ff && !msk_ff) [*2];
    endsequence
    AST_ACCESS: assert property (s_access |=> pready)
        else $error("no answer in second access cycle");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_ERR_RD: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    AST_OE_OFF: assert property (s_off |-> pwm_oe == '0)
        else $error("pin kept under pwm control while disabled");
    AST_CNT_OFF: assert property (s_off_long ##0 (pready && !pwrite && paddr == A_CNT) |-> prdata == 32'h0)
        else $error("counter not zero while disabled");
    AST_IRQ_OFF: assert property (s_quiet |-> !irq)
        else $error("irq with every source disabled");
    AST_IRQ_HOLD: assert property (irq && !wr && !$past(wr) |=> irq)
        else $error("irq dropped without a write");
endmodule
bind pwm_shared_period pwm_shared_period_monitor i_mon (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
`default_nettype wire

// file: bench/pwm_shared_period_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_shared_period_tb
    import pwm_shared_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [11:0] A_CFG = {IDX_CFG, 2'b00};
    localparam logic [11:0] A_PER = {IDX_PER_LO, 2'b00};
    localparam logic [11:0] A_IE  = {IDX_IRQ_EN, 2'b00};
    localparam logic [11:0] A_STAT = {IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] A_MSK = {IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_CNT = {IDX_COUNT, 2'b00};
    localparam logic [11:0] A_CH0 = {IDX_CH_BASE, 2'b00};
    logic              clk, rst, psel, penable, pwrite, pready, pslverr, irq, serr;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rdat;
    logic [NUM_CH-1:0] pwm_out, pwm_oe;
    int                err_total = 0;
    int                compares = 0;
    int                cyc = 0;
    int                n;
    int                t0;

    pwm_shared_period i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));

    // free-running clock and a hang guard sized well above the longest scenario
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            finish_test();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic finish_test();
        if (err_total == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // one whole transfer; waits an edge first so psel is never set twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        apb(0, A_CFG, 0); chk(rdat, 32'h0);
        apb(0, A_PER, 0); chk(rdat, 32'h0);
        apb(0, A_IE, 0); chk(rdat, 32'h0);
        apb(1, A_CFG, 32'h7f); apb(0, A_CFG, 0); chk(rdat, 32'h7f);
        apb(1, A_PER, 32'ha5); apb(0, A_PER, 0); chk(rdat, 32'ha5);
        apb(1, A_CFG, 32'h0);
        apb(0, 12'h000, 0); chk({rdat[30:0], serr}, 32'h1);
        apb(1, A_CNT, 32'h1); chk(serr, 1);
    endtask
    // waits for the next high pulse of channel 0 and counts its length in n
    task automatic hi_len();
        while (pwm_out[0] !== 1'b1) @(posedge clk);
        n = 0;
        while (pwm_out[0] === 1'b1) begin
            @(posedge clk);
            n++;
        end
    endtask
    // high time equals the duty; a duty written late in a period must wait for the next one
    task automatic t_duty();
        apb(1, A_CH0, 32'h8005);
        apb(1, A_PER, 32'h0f);
        apb(1, A_CFG, 32'h80);
        hi_len();
        chk(n, 5);
        apb(1, A_CH0, 32'h800c);
        hi_len();
        chk(n, 12);
        chk(pwm_oe[0], 1);
        apb(1, A_CFG, 32'h0);
        repeat (3) @(posedge clk);
        chk(pwm_oe, 0);
    endtask
    // rise to rise of irq is one full period, the high nibble makes it 0x10f + 1 ticks;
    // the flag clear also raises the period, which must not stretch the running one
    task automatic t_period(input logic [1:0] cks);
        apb(1, A_PER, 32'h0f);
        apb(1, A_IE, 32'h2);
        apb(1, A_CFG, {24'h0, 2'b10, cks, 4'h1});
        while (irq !== 1'b1) @(posedge clk);
        t0 = cyc;
        repeat (3) @(posedge clk);
        chk(irq, 1);
        apb(1, A_CFG, {24'h0, 2'b10, cks, 4'h2});
        while (irq === 1'b1) @(posedge clk);
        while (irq !== 1'b1) @(posedge clk);
        chk(cyc - t0, 272 << cks);
        apb(1, A_CFG, 32'h0);
    endtask
    // timer use with every pin off: flag sets but stays silent while masked
    task automatic t_mask();
        apb(1, A_CH0, 32'h0);
        apb(1, A_IE, 32'h0);
        apb(1, A_CFG, 32'h81);
        repeat (300) @(posedge clk);
        chk(irq, 0);
        apb(0, A_CFG, 0); chk(rdat, 32'hc1);
        apb(1, A_CFG, 32'h0);
        apb(0, A_CNT, 0); chk(rdat, 32'h0);
        // sticky status bit reaches irq only through its mask and clears on a written one
        apb(0, A_STAT, 0); chk(rdat, 32'h1);
        apb(1, A_MSK, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1);
        apb(1, A_STAT, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 0);
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_duty();
        for (int k = 0; k < 4; k++) t_period(2'(k));
        t_mask();
        finish_test();
    end
endmodule
`default_nettype wire

// file: common/pwm_shared_pkg.sv
package pwm_shared_pkg;

    // ------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_IRQ_EN    = 10'h0a9;
    localparam logic [9:0] IDX_PER_LO    = 10'h0d3;
    localparam logic [9:0] IDX_CFG       = 10'h0d4;
    localparam logic [9:0] IDX_CH_BASE   = 10'h0c0;
    localparam logic [9:0] IDX_IRQ_STAT  = 10'h0e0;
    localparam logic [9:0] IDX_IRQ_MASK  = 10'h0e1;
    localparam logic [9:0] IDX_COUNT     = 10'h0e2;

    // ------------------------------------------------------------
    // sizes and field positions
    // ------------------------------------------------------------
    localparam int unsigned NUM_CH       = 8;
    localparam int unsigned CNT_W        = 12;
    localparam int unsigned CFG_EN_BIT   = 7;
    localparam int unsigned CFG_FLAG_BIT = 6;
    localparam int unsigned CFG_CKS_LSB  = 4;
    localparam int unsigned IRQ_EN_BIT   = 1;
    localparam int unsigned CH_EN_BIT    = 15;
    localparam int unsigned CH_INV_BIT   = 14;
    localparam int unsigned STAT_OVF_BIT = 0;
    localparam logic [7:0]  IRQ_EN_WMASK = 8'h2f;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  CFG_RST      = 8'h00;
    localparam logic [7:0]  PER_LO_RST   = 8'h00;
    localparam logic [7:0]  IRQ_EN_RST   = 8'h00;
    localparam logic [7:0]  STAT_RST     = 8'h00;
    localparam logic [7:0]  MASK_RST     = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic             en;
        logic             inv;
        logic [CNT_W-1:0] duty;
    } chan_cfg_t;

    localparam chan_cfg_t CH_RST = '{en: 1'b0, inv: 1'b0, duty: 12'h000};

    typedef enum logic [1:0] {
        RUN_OFF   = 2'b00,
        RUN_START = 2'b01,
        RUN_COUNT = 2'b11
    } run_state_t;

endpackage

// file: verilog/pwm_shared_period.sv
// What this block does
// - while the module enable is 1 the prescaled clock drives the unit and each pin follows its channel output enable.
// - while the module enable is 0 the unit stops, the counter is held at zero and every pin returns to GPIO.
// - the counter passing the period value sets the overflow flag in bit 6 of the general config register.
// - an interrupt is requested while the overflow flag and the overflow enable in bit 1 of the enable register are set.
// - the flag stays set after the interrupt and only a software write clears it.
// - the clock select field picks the oscillator divided by 1, 2, 4 or 8 for codes 00, 01, 10, 11.
// - one period lasts the 12-bit period value plus one counting clocks.
// - the period value is the config register's low nibble above the 8 bits of the period-low register.
// - config and period-low registers are fully read/write and reset to zero.
// - with inversion off a channel is high for its duty value in counting clocks from the period start.
// - a new duty value applies from the next period only.
// - a new period value applies from the next period only.
// - with the module on and every channel output off the counter still runs and still raises overflows.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module pwm_shared_period
    import pwm_shared_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [NUM_CH-1:0] pwm_out,
    output logic      [NUM_CH-1:0] pwm_oe,
    output logic                   irq
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]       cfg_ff;
    logic [7:0]       per_lo_ff;
    logic [7:0]       irq_en_ff;
    logic [7:0]       stat_ff;
    logic [7:0]       mask_ff;
    chan_cfg_t        ch_cfg_ff  [NUM_CH];
    logic [CNT_W-1:0] act_duty_ff[NUM_CH];
    logic [CNT_W-1:0] act_per_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [2:0]       div_ff;
    run_state_t       state_ff;
    logic [31:0]      prdata_ff;
    logic             pready_ff;
    logic             pslverr_ff;
    logic             irq_ff;
    logic [NUM_CH-1:0] pwm_out_ff;
    logic [NUM_CH-1:0] pwm_oe_ff;

    logic [7:0]       nxt_cfg;
    logic [7:0]       nxt_stat;
    logic [CNT_W-1:0] nxt_cnt;
    logic [2:0]       nxt_div;
    run_state_t       nxt_state;
    logic             nxt_irq;
    logic [NUM_CH-1:0] nxt_out;
    logic [NUM_CH-1:0] nxt_oe;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire logic [9:0]  idx      = paddr[11:2];
    wire logic        setup_ok = psel & penable & ~pready_ff;
    wire logic        commit   = psel & penable & pready_ff;
    wire logic        wr       = commit & pwrite;
    wire logic        hit_irq_en = (idx == IDX_IRQ_EN);
    wire logic        hit_lo   = (idx == IDX_PER_LO);
    wire logic        hit_cfg  = (idx == IDX_CFG);
    wire logic        hit_stat = (idx == IDX_IRQ_STAT);
    wire logic        hit_mask = (idx == IDX_IRQ_MASK);
    wire logic        hit_cnt  = (idx == IDX_COUNT);
    wire logic        hit_ch   = (idx[9:3] == IDX_CH_BASE[9:3]);
    wire logic [2:0]  ch_sel   = idx[2:0];
    wire logic        mapped   = hit_irq_en | hit_lo | hit_cfg | hit_stat | hit_mask | hit_cnt | hit_ch;
    // the counter readback is a status view, writing it is an error
    wire logic        bad      = ~mapped | (hit_cnt & pwrite);

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    wire logic             mod_en     = cfg_ff[CFG_EN_BIT];
    wire logic             ovf_flag   = cfg_ff[CFG_FLAG_BIT];
    wire logic [1:0]       count_clock_select = cfg_ff[CFG_CKS_LSB +: 2];
    wire logic [CNT_W-1:0] shared_period_value = {cfg_ff[3:0], per_lo_ff};
    wire logic             overflow_irq_enable = irq_en_ff[IRQ_EN_BIT];

    // ------------------------------------------------------------
    // prescaler: low bits of a free divider all ones
    // ------------------------------------------------------------
    // mask 000/001/011/111 gives one tick every 1, 2, 4, 8 clocks
    wire logic [2:0] div_mask = 3'((4'h1 << count_clock_select) - 4'h1);
    wire logic       tick     = (state_ff == RUN_COUNT) & ((div_ff & div_mask) == div_mask);
    wire logic       wrap     = tick & (cnt_ff == act_per_ff);
    wire logic       ovf_evt  = wrap;

    // ------------------------------------------------------------
    // run state machine
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            RUN_OFF: begin
                if (mod_en) begin
                    nxt_state = RUN_START;
                end
            end
            RUN_START: begin
                nxt_state = mod_en ? RUN_COUNT : RUN_OFF;
            end
            RUN_COUNT: begin
                if (!mod_en) begin
                    nxt_state = RUN_OFF;
                end
            end
            default: begin
                nxt_state = RUN_OFF;
            end
        endcase
    end

    // ------------------------------------------------------------
    // counter and divider
    // ------------------------------------------------------------
    // the divider restarts with the module so the first period is full length
    assign nxt_div = (state_ff == RUN_COUNT) ? 3'(div_ff + 3'h1) : 3'h0;
    assign nxt_cnt = (state_ff != RUN_COUNT || wrap) ? '0 :
                     tick ? CNT_W'(cnt_ff + 1'b1) : cnt_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= RUN_OFF;
            cnt_ff   <= '0;
            div_ff   <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            div_ff   <= nxt_div;
        end
    end

    // active period copy only moves at a period boundary or at start
    always_ff @(posedge clk) begin
        if (rst) begin
            act_per_ff <= '0;
        end else if (state_ff != RUN_COUNT || wrap) begin
            act_per_ff <= shared_period_value;
        end
    end

    // ------------------------------------------------------------
    // config and period-low registers
    // ------------------------------------------------------------
    // a wrap in the same cycle as a clearing write keeps the flag set
    always_comb begin
        nxt_cfg = cfg_ff;
        if (wr && hit_cfg) begin
            nxt_cfg = pwdata[7:0];
        end
        if (ovf_evt) begin
            nxt_cfg[CFG_FLAG_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_ff    <= CFG_RST;
            per_lo_ff <= PER_LO_RST;
            irq_en_ff <= IRQ_EN_RST;
            mask_ff   <= MASK_RST;
        end else begin
            cfg_ff <= nxt_cfg;
            if (wr && hit_lo) begin
                per_lo_ff <= pwdata[7:0];
            end
            if (wr && hit_irq_en) begin
                irq_en_ff <= pwdata[7:0] & IRQ_EN_WMASK;
            end
            if (wr && hit_mask) begin
                mask_ff <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status, mask and output
    // ------------------------------------------------------------
    // sticky status is write-one-to-clear; a new event beats the clear
    always_comb begin
        nxt_stat = stat_ff;
        if (wr && hit_stat) begin
            nxt_stat = stat_ff & ~pwdata[7:0];
        end
        if (ovf_evt) begin
            nxt_stat[STAT_OVF_BIT] = 1'b1;
        end
    end

    assign nxt_irq = (ovf_flag & overflow_irq_enable) | (|(stat_ff & mask_ff));

    always_ff @(posedge clk) begin
        if (rst) begin
            stat_ff <= STAT_RST;
            irq_ff  <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            irq_ff  <= nxt_irq;
        end
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            wire logic ch_wr   = wr & hit_ch & (ch_sel == 3'(g));
            // duty 0 keeps the pin low, a duty above the period keeps it high
            wire logic ch_high = (state_ff == RUN_COUNT) & (cnt_ff < act_duty_ff[g]);

            always_ff @(posedge clk) begin
                if (rst) begin
                    ch_cfg_ff[g]   <= CH_RST;
                    act_duty_ff[g] <= '0;
                end else begin
                    if (ch_wr) begin
                        ch_cfg_ff[g] <= '{en:   pwdata[CH_EN_BIT],
                                          inv:  pwdata[CH_INV_BIT],
                                          duty: pwdata[CNT_W-1:0]};
                    end
                    if (state_ff != RUN_COUNT || wrap) begin
                        act_duty_ff[g] <= ch_cfg_ff[g].duty;
                    end
                end
            end

            assign nxt_out[g] = ch_high ^ ch_cfg_ff[g].inv;
            assign nxt_oe[g]  = mod_en & ch_cfg_ff[g].en;
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_out_ff <= '0;
            pwm_oe_ff  <= '0;
        end else begin
            pwm_out_ff <= nxt_out;
            pwm_oe_ff  <= nxt_oe;
        end
    end

    // ------------------------------------------------------------
    // read mux and bus answer
    // ------------------------------------------------------------
    wire chan_cfg_t   ch_rd   = ch_cfg_ff[ch_sel];
    wire logic [31:0] ch_word = {16'h0000, ch_rd.en, ch_rd.inv, 2'b00, ch_rd.duty};
    wire logic [31:0] rd_mux  = hit_cfg  ? {24'h000000, cfg_ff} :
                                hit_lo   ? {24'h000000, per_lo_ff} :
                                hit_irq_en ? {24'h000000, irq_en_ff} :
                                hit_stat ? {24'h000000, stat_ff} :
                                hit_mask ? {24'h000000, mask_ff} :
                                hit_cnt  ? {20'h00000, cnt_ff} :
                                hit_ch   ? ch_word : 32'h00000000;

    // one wait state: the answer is registered so every bus output is a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= setup_ok;
            pslverr_ff <= setup_ok & bad;
            if (setup_ok && !pwrite) begin
                prdata_ff <= rd_mux;
            end
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;
    assign pwm_out = pwm_out_ff;
    assign pwm_oe  = pwm_oe_ff;
    assign irq     = irq_ff;

endmodule

`default_nettype wire
